// ==== logic/hcrb_consts.vh ====
/*
  Constants of the heater configuration register bank: register indices,
  highest writable codes, field bit positions and reset values.
  Assumes inclusion by bare name from the design file.
*/
`ifndef HCRB_CONSTS_VH
`define HCRB_CONSTS_VH

// Register indices; byte address is four times the index
`define HCRB_IDX_WORK_MODE 8'h15
`define HCRB_IDX_HEAT_MODE 8'h16
`define HCRB_IDX_REG_TYPE 8'h17
`define HCRB_IDX_PV_SRC 8'h18
`define HCRB_IDX_TC_A 8'h19
`define HCRB_IDX_TC_B 8'h1a
`define HCRB_IDX_DIODE_A 8'h1b
`define HCRB_IDX_DIODE_B 8'h1c
`define HCRB_IDX_RES_SENS 8'h1d
`define HCRB_IDX_PV_UNIT 8'h1e
`define HCRB_IDX_RACT 8'h1f
`define HCRB_IDX_RACT_U 8'h20
`define HCRB_IDX_RIDL 8'h21
`define HCRB_IDX_RIDL_U 8'h22
`define HCRB_IDX_BACT 8'h23
`define HCRB_IDX_BACT_U 8'h24
`define HCRB_IDX_BIDL 8'h25
`define HCRB_IDX_CFG 8'h26
`define HCRB_IDX_STAT 8'h27

// Highest writable code per enumerated register
`define HCRB_MAX_WORK_MODE 8'h01
`define HCRB_MAX_HEAT_MODE 8'h01
`define HCRB_MAX_REG_TYPE 8'h01
`define HCRB_MAX_PV_SRC 8'h06
`define HCRB_MAX_TC 8'h03
`define HCRB_MAX_DIODE 8'h01
`define HCRB_MAX_RES_SENS 8'h00
`define HCRB_MAX_PV_UNIT 8'h02
`define HCRB_MAX_RAMP_U 8'h02

// Reported-only codes
`define HCRB_WM_EXTERN 8'h02
`define HCRB_WM_PID_OUT 8'h03
`define HCRB_PVU_VOLT 8'h03

// Fields of the fitted-module register and the status register
`define HCRB_CFG_HV_BIT 0
`define HCRB_CFG_DUAL_BIT 1
`define HCRB_STAT_REJ_BIT 0
`define HCRB_STAT_SLVERR_BIT 1

// Reset values
`define HCRB_RST_CODE 8'h00
`define HCRB_RST_RAMP 16'h0000

`endif

// ==== logic/hcrb_bank.v ====
/*
  APB register bank holding the first channel configuration of a dual-mode
  heating supply. Assumes an APB master on pclk; module fit straps are levels
  steady while the bank runs, and the status inputs come from the regulator.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hcrb_consts.vh"

// Behaviour
// - Work mode: 0 manual, 1 automatic writable; 2 and 3 reported only.
// - Heating mode: 0 resistive, 1 bombard; meaningful only with high voltage module.
// - Regulation type: 0 temperature, 1 temperature ramp.
// - Process value source codes 0 to 6 select the input.
// - Thermocouple A type codes 0 to 3: K, C, E, N.
// - Thermocouple B type uses the same four codes.
// - Diode A type selects curve 0 or curve 1.
// - Diode B type selects curve 0 or curve 1.
// - Resistance sensor type accepts only code 0, platinum 100 ohm.
// - Unit: 0 Kelvin, 1 Celsius, 2 Fahrenheit; 3 volts reported only.
// - Resistive active ramp is signed 16 bit, rate times 100.
// - Ramp unit codes: 0 per second, 1 per minute, 2 per hour.
// - Resistive idle ramp is signed 16 bit, scaled by 100.
// - Bombard active ramp, or second channel active ramp with dual modules.
// - Bombard idle ramp, or second channel idle ramp with dual modules.
// - Module-flagged entries apply only when that module is fitted.
// - Enumerated registers unsigned 8 bit; ramps signed 16 bit.
module hcrb_bank (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire high_voltage_module_fitted,
  input wire dual_dc_fitted,
  input wire extern_control_active,
  input wire regulator_output_active,
  input wire volt_input_active,
  output wire [1:0] work_mode,
  output wire heat_bombard,
  output wire ramp_regulation,
  output wire [2:0] pv_source,
  output wire [1:0] tc_a_type,
  output wire [1:0] tc_b_type,
  output wire diode_a_curve,
  output wire diode_b_curve,
  output wire [1:0] pv_unit,
  output wire signed [15:0] res_active_ramp,
  output wire [1:0] res_active_ramp_unit,
  output wire signed [15:0] res_idle_ramp,
  output wire [1:0] res_idle_ramp_unit,
  output wire signed [15:0] bomb_active_ramp,
  output wire [1:0] bomb_active_ramp_unit,
  output wire signed [15:0] bomb_idle_ramp,
  output wire signed [15:0] ch2_active_ramp,
  output wire signed [15:0] ch2_idle_ramp,
  output wire [1:0] ch2_active_ramp_unit
);

  reg [7:0] work_mode_r;
  reg [7:0] heat_mode_r;
  reg [7:0] reg_type_r;
  reg [7:0] pv_src_r;
  reg [7:0] tc_a_r;
  reg [7:0] tc_b_r;
  reg [7:0] diode_a_r;
  reg [7:0] diode_b_r;
  reg [7:0] res_sens_r;
  reg [7:0] pv_unit_r;
  reg [15:0] ract_r;
  reg [7:0] ract_u_r;
  reg [15:0] ridl_r;
  reg [7:0] ridl_u_r;
  reg [15:0] bact_r;
  reg [7:0] bact_u_r;
  reg [15:0] bidl_r;
  reg rejected_r;
  reg [31:0] prdata_r;
  reg pslverr_r;
  reg [31:0] rd_nxt;
  reg hit_nxt;

  wire [9:0] idx;
  wire wr_acc;
  wire rd_acc;
  wire [7:0] wb;
  wire [15:0] wh;
  wire lo_ok;
  wire hi_ok;
  wire wr_bad;
  wire [7:0] wm_view;
  wire [7:0] pvu_view;

  // Code is accepted only if at or below the highest writable value
  function code_ok;
    input [7:0] code;
    input [7:0] max_code;
    begin
      code_ok = (code <= max_code);
    end
  endfunction

  function [31:0] zx8;
    input [7:0] v;
    begin
      zx8 = {24'h00_0000, v};
    end
  endfunction

  // Ramps read back sign-extended so software sees a signed word
  function [31:0] sx16;
    input [15:0] v;
    begin
      sx16 = {{16{v[15]}}, v};
    end
  endfunction

  // Write acceptance shared by the write decode and the reject flag
  function wr_ok;
    input [9:0] a;
    input [7:0] b;
    input lo;
    input hi;
    input hv;
    input dual;
    begin
      case (a)
        {2'b00, `HCRB_IDX_WORK_MODE}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_WORK_MODE);
        end
        {2'b00, `HCRB_IDX_HEAT_MODE}: begin
          wr_ok = lo && hv && code_ok(b, `HCRB_MAX_HEAT_MODE);
        end
        {2'b00, `HCRB_IDX_REG_TYPE}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_REG_TYPE);
        end
        {2'b00, `HCRB_IDX_PV_SRC}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_PV_SRC);
        end
        {2'b00, `HCRB_IDX_TC_A}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_TC);
        end
        {2'b00, `HCRB_IDX_TC_B}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_TC);
        end
        {2'b00, `HCRB_IDX_DIODE_A}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_DIODE);
        end
        {2'b00, `HCRB_IDX_DIODE_B}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_DIODE);
        end
        {2'b00, `HCRB_IDX_RES_SENS}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_RES_SENS);
        end
        {2'b00, `HCRB_IDX_PV_UNIT}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_PV_UNIT);
        end
        // Ramps need both low lanes so a half-written rate never lands
        {2'b00, `HCRB_IDX_RACT}: begin
          wr_ok = hi;
        end
        {2'b00, `HCRB_IDX_RACT_U}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_RAMP_U);
        end
        {2'b00, `HCRB_IDX_RIDL}: begin
          wr_ok = hi;
        end
        {2'b00, `HCRB_IDX_RIDL_U}: begin
          wr_ok = lo && code_ok(b, `HCRB_MAX_RAMP_U);
        end
        // Bombard area serves either fitted module; a bare supply refuses it
        {2'b00, `HCRB_IDX_BACT}: begin
          wr_ok = hi && (hv || dual);
        end
        {2'b00, `HCRB_IDX_BACT_U}: begin
          wr_ok = lo && (hv || dual) && code_ok(b, `HCRB_MAX_RAMP_U);
        end
        {2'b00, `HCRB_IDX_BIDL}: begin
          wr_ok = hi && (hv || dual);
        end
        // Status words take writes silently: nothing is stored and the reject flag clears
        {2'b00, `HCRB_IDX_CFG}: begin
          wr_ok = 1'b1;
        end
        {2'b00, `HCRB_IDX_STAT}: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
    end
  endfunction

  assign idx = paddr[11:2];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign wb = pwdata[7:0];
  assign wh = pwdata[15:0];
  // 8-bit fields need lane 0, 16-bit fields both low lanes; partial writes dropped
  assign lo_ok = pstrb[0];
  assign hi_ok = pstrb[0] && pstrb[1];

  // Reported-only work mode and unit override the stored setting
  assign wm_view = regulator_output_active ? `HCRB_WM_PID_OUT :
                   extern_control_active ? `HCRB_WM_EXTERN : work_mode_r;
  assign pvu_view = volt_input_active ? `HCRB_PVU_VOLT : pv_unit_r;

  // Write decode with range checks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_mode_r <= `HCRB_RST_CODE;
      heat_mode_r <= `HCRB_RST_CODE;
      reg_type_r <= `HCRB_RST_CODE;
      pv_src_r <= `HCRB_RST_CODE;
      tc_a_r <= `HCRB_RST_CODE;
      tc_b_r <= `HCRB_RST_CODE;
      diode_a_r <= `HCRB_RST_CODE;
      diode_b_r <= `HCRB_RST_CODE;
      res_sens_r <= `HCRB_RST_CODE;
      pv_unit_r <= `HCRB_RST_CODE;
      ract_r <= `HCRB_RST_RAMP;
      ract_u_r <= `HCRB_RST_CODE;
      ridl_r <= `HCRB_RST_RAMP;
      ridl_u_r <= `HCRB_RST_CODE;
      bact_r <= `HCRB_RST_RAMP;
      bact_u_r <= `HCRB_RST_CODE;
      bidl_r <= `HCRB_RST_RAMP;
    end else if (wr_acc && wr_ok(idx, wb, lo_ok, hi_ok, high_voltage_module_fitted, dual_dc_fitted)) begin
      case (idx)
        {2'b00, `HCRB_IDX_WORK_MODE}: begin
          work_mode_r <= wb;
        end
        {2'b00, `HCRB_IDX_HEAT_MODE}: begin
          heat_mode_r <= wb;
        end
        {2'b00, `HCRB_IDX_REG_TYPE}: begin
          reg_type_r <= wb;
        end
        {2'b00, `HCRB_IDX_PV_SRC}: begin
          pv_src_r <= wb;
        end
        {2'b00, `HCRB_IDX_TC_A}: begin
          tc_a_r <= wb;
        end
        {2'b00, `HCRB_IDX_TC_B}: begin
          tc_b_r <= wb;
        end
        {2'b00, `HCRB_IDX_DIODE_A}: begin
          diode_a_r <= wb;
        end
        {2'b00, `HCRB_IDX_DIODE_B}: begin
          diode_b_r <= wb;
        end
        {2'b00, `HCRB_IDX_RES_SENS}: begin
          res_sens_r <= wb;
        end
        {2'b00, `HCRB_IDX_PV_UNIT}: begin
          pv_unit_r <= wb;
        end
        {2'b00, `HCRB_IDX_RACT}: begin
          ract_r <= wh;
        end
        {2'b00, `HCRB_IDX_RACT_U}: begin
          ract_u_r <= wb;
        end
        {2'b00, `HCRB_IDX_RIDL}: begin
          ridl_r <= wh;
        end
        {2'b00, `HCRB_IDX_RIDL_U}: begin
          ridl_u_r <= wb;
        end
        {2'b00, `HCRB_IDX_BACT}: begin
          bact_r <= wh;
        end
        {2'b00, `HCRB_IDX_BACT_U}: begin
          bact_u_r <= wb;
        end
        {2'b00, `HCRB_IDX_BIDL}: begin
          bidl_r <= wh;
        end
        default: begin
        end
      endcase
    end
  end

  // Flags a refused write to a mapped register; a later good write clears it
  assign wr_bad = wr_acc && hit_nxt && !wr_ok(idx, wb, lo_ok, hi_ok, high_voltage_module_fitted, dual_dc_fitted);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rejected_r <= 1'b0;
    end else if (wr_acc && hit_nxt) begin
      rejected_r <= wr_bad;
    end
  end

  // Read mux; also tells whether the address is mapped
  always @* begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (idx)
      {2'b00, `HCRB_IDX_WORK_MODE}: rd_nxt = zx8(wm_view);
      {2'b00, `HCRB_IDX_HEAT_MODE}: rd_nxt = zx8(heat_mode_r);
      {2'b00, `HCRB_IDX_REG_TYPE}: rd_nxt = zx8(reg_type_r);
      {2'b00, `HCRB_IDX_PV_SRC}: rd_nxt = zx8(pv_src_r);
      {2'b00, `HCRB_IDX_TC_A}: rd_nxt = zx8(tc_a_r);
      {2'b00, `HCRB_IDX_TC_B}: rd_nxt = zx8(tc_b_r);
      {2'b00, `HCRB_IDX_DIODE_A}: rd_nxt = zx8(diode_a_r);
      {2'b00, `HCRB_IDX_DIODE_B}: rd_nxt = zx8(diode_b_r);
      {2'b00, `HCRB_IDX_RES_SENS}: rd_nxt = zx8(res_sens_r);
      {2'b00, `HCRB_IDX_PV_UNIT}: rd_nxt = zx8(pvu_view);
      {2'b00, `HCRB_IDX_RACT}: rd_nxt = sx16(ract_r);
      {2'b00, `HCRB_IDX_RACT_U}: rd_nxt = zx8(ract_u_r);
      {2'b00, `HCRB_IDX_RIDL}: rd_nxt = sx16(ridl_r);
      {2'b00, `HCRB_IDX_RIDL_U}: rd_nxt = zx8(ridl_u_r);
      {2'b00, `HCRB_IDX_BACT}: rd_nxt = sx16(bact_r);
      {2'b00, `HCRB_IDX_BACT_U}: rd_nxt = zx8(bact_u_r);
      {2'b00, `HCRB_IDX_BIDL}: rd_nxt = sx16(bidl_r);
      {2'b00, `HCRB_IDX_CFG}: begin
        rd_nxt[`HCRB_CFG_HV_BIT] = high_voltage_module_fitted;
        rd_nxt[`HCRB_CFG_DUAL_BIT] = dual_dc_fitted;
      end
      {2'b00, `HCRB_IDX_STAT}: rd_nxt[`HCRB_STAT_REJ_BIT] = rejected_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  // Zero-wait slave: read data and error registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= !hit_nxt;
    end
  end

  assign pready = 1'b1;
  assign prdata = rd_acc ? prdata_r : 32'h0000_0000;
  assign pslverr = psel && penable && pslverr_r;

  assign work_mode = wm_view[1:0];
  assign heat_bombard = high_voltage_module_fitted && heat_mode_r[0];
  assign ramp_regulation = reg_type_r[0];
  assign pv_source = pv_src_r[2:0];
  assign tc_a_type = tc_a_r[1:0];
  assign tc_b_type = tc_b_r[1:0];
  assign diode_a_curve = diode_a_r[0];
  assign diode_b_curve = diode_b_r[0];
  assign pv_unit = pvu_view[1:0];
  assign res_active_ramp = ract_r;
  assign res_active_ramp_unit = ract_u_r[1:0];
  assign res_idle_ramp = ridl_r;
  assign res_idle_ramp_unit = ridl_u_r[1:0];
  // Same storage serves bombard or second channel depending on fitted modules
  assign bomb_active_ramp = high_voltage_module_fitted ? bact_r : 16'h0000;
  assign bomb_idle_ramp = high_voltage_module_fitted ? bidl_r : 16'h0000;
  assign bomb_active_ramp_unit = high_voltage_module_fitted ? bact_u_r[1:0] : 2'h0;
  assign ch2_active_ramp = dual_dc_fitted ? bact_r : 16'h0000;
  assign ch2_idle_ramp = dual_dc_fitted ? bidl_r : 16'h0000;
  assign ch2_active_ramp_unit = dual_dc_fitted ? bact_u_r[1:0] : 2'h0;

endmodule // hcrb_bank

`default_nettype wire

// ==== dv/hcrb_bank_properties.sv ====
/*
  Port checker of the heater configuration register bank.
  Assumes binding to hcrb_bank; one clock pclk, reset presetn active low.
*/
`timescale 1ns/1ns
`default_nettype none
module hcrb_bank_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic high_voltage_module_fitted,
  input wire logic dual_dc_fitted,
  input wire logic extern_control_active,
  input wire logic regulator_output_active,
  input wire logic volt_input_active,
  input wire logic [1:0] work_mode,
  input wire logic heat_bombard,
  input wire logic [2:0] pv_source,
  input wire logic [1:0] tc_a_type,
  input wire logic [1:0] pv_unit,
  input wire logic signed [15:0] res_active_ramp,
  input wire logic [1:0] res_idle_ramp_unit,
  input wire logic signed [15:0] bomb_active_ramp,
  input wire logic signed [15:0] ch2_active_ramp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup(i);
    psel && !penable && paddr[11:2] == i;
  endsequence
  // Setup then access; data held, so sampled at the access edge
  sequence s_wr(i);
    s_setup(i) ##1 psel && penable && pwrite;
  endsequence
  AST_WM_PID: assert property (regulator_output_active |-> work_mode == 2'd3)
    else $error("work mode not showing regulator output");
  AST_WM_EXT: assert property (extern_control_active && !regulator_output_active |-> work_mode == 2'd2)
    else $error("work mode not showing external control");
  AST_WM_CODE: assert property (!extern_control_active && !regulator_output_active |-> !work_mode[1])
    else $error("work mode holds a reported-only code");
  AST_PV_SRC: assert property (pv_source <= 3'd6)
    else $error("process value source above 6");
  AST_UNIT: assert property ((pv_unit == 2'd3) == volt_input_active)
    else $error("unit volt code without volt input");
  AST_TC_A: assert property (s_wr(8'h19) ##0 pstrb[0] && pwdata[7:0] <= 8'd3 |=> tc_a_type == $past(pwdata[1:0]))
    else $error("thermocouple a type not written");
  AST_HEAT: assert property (s_wr(8'h16) ##0 !high_voltage_module_fitted |=> $stable(heat_bombard))
    else $error("heating mode changed without high voltage module");
  AST_HEAT_WR: assert property (s_wr(8'h16) ##0 high_voltage_module_fitted && pstrb[0] && pwdata[7:0] <= 8'd1
    |=> heat_bombard == $past(pwdata[0]))
    else $error("heating mode not written with high voltage module");
  AST_RAMP_WR: assert property (s_wr(8'h1f) ##0 pstrb[1:0] == 2'b11 |=> res_active_ramp == $past(pwdata[15:0]))
    else $error("resistive active ramp not written");
  AST_RD_SEXT: assert property (psel && penable && !pwrite && paddr[11:2] == 10'h1f
    |-> prdata == {{16{res_active_ramp[15]}}, res_active_ramp})
    else $error("ramp readback not sign extended");
  AST_RU_REJ: assert property (s_wr(8'h22) ##0 pwdata[7:0] > 8'd2 |=> $stable(res_idle_ramp_unit))
    else $error("ramp unit took an undefined code");
  AST_BOMB: assert property (!high_voltage_module_fitted |-> bomb_active_ramp == 16'h0000)
    else $error("bombard ramp shown without module");
  AST_CH2: assert property (!dual_dc_fitted |-> ch2_active_ramp == 16'h0000)
    else $error("second channel ramp shown without dual modules");
endmodule // hcrb_bank_chk
bind hcrb_bank hcrb_bank_chk i_chk (.*);
`default_nettype wire

// ==== dv/hcrb_bank_tb_top.sv ====
/*
  Self-checking bench of the heater configuration bank: random and corner APB traffic.
  Assumes the bank answers APB with pready and keeps straps steady per phase.
*/
`timescale 1ns/1ns
`default_nettype none
module hcrb_bank_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, erv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'hda71_193d, rdv, r, d;
  logic [3:0] pstrb = 4'h0;
  logic high_voltage_module_fitted = 0, dual_dc_fitted = 0, extern_control_active = 0;
  logic regulator_output_active = 0, volt_input_active = 0;
  logic [7:0] i;
  logic [31:0] model [21:39];
  wire [31:0] prdata;
  wire pready, pslverr, heat_bombard, ramp_regulation, diode_a_curve, diode_b_curve;
  wire [1:0] work_mode, tc_a_type, tc_b_type, pv_unit, res_active_ramp_unit, res_idle_ramp_unit;
  wire [1:0] bomb_active_ramp_unit, ch2_active_ramp_unit;
  wire [2:0] pv_source;
  wire signed [15:0] res_active_ramp, res_idle_ramp, bomb_active_ramp, bomb_idle_ramp, ch2_active_ramp, ch2_idle_ramp;
  integer n_mismatch = 0, n_tests = 0, p, j;
  hcrb_bank i_dut (.*);
  always #5 pclk = ~pclk;
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Highest writable code; ff marks a 16-bit ramp
  function automatic [7:0] mx(input [7:0] a);
    case (a)
      8'h18: mx = 8'h06;
      8'h19, 8'h1a: mx = 8'h03;
      8'h1d: mx = 8'h00;
      8'h1e, 8'h20, 8'h22, 8'h24: mx = 8'h02;
      8'h1f, 8'h21, 8'h23, 8'h25: mx = 8'hff;
      default: mx = 8'h01;
    endcase
  endfunction
  function automatic bit ok(input [7:0] a, input [31:0] v, input [3:0] s);
    // Status words take writes silently
    if (a > 8'h25)
      return a < 8'h28;
    if ((a == 8'h16 && !high_voltage_module_fitted) || (a > 8'h22 && !high_voltage_module_fitted && !dual_dc_fitted))
      return 0;
    if (mx(a) == 8'hff)
      return s[1:0] == 2'b11;
    return s[0] && v[7:0] <= mx(a);
  endfunction
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input [31:0] g, input [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Leaves psel up so a following call makes a back-to-back setup
  task automatic apb(input bit w, input [7:0] a, input [31:0] v, input [3:0] s);
    integer k;
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= v;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    erv = pslverr;
    penable <= 0;
    if (k >= 20) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic idle;
    psel <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input [7:0] a, input [31:0] v, input [3:0] s);
    bit g;
    g = ok(a, v, s);
    apb(1, a, v, s);
    chk({31'b0, erv}, {31'b0, a < 8'h15 || a > 8'h27});
    if (a >= 8'h15 && a <= 8'h27)
      model[39] = {31'b0, !g};
    if (g && a >= 8'h15 && a < 8'h26)
      model[a] = mx(a) == 8'hff ? {{16{v[15]}}, v[15:0]} : {24'h0, v[7:0]};
  endtask
  task automatic rd(input [7:0] a);
    apb(0, a, seed, 4'h0);
    if (a == 8'h27)
      rdv = rdv & 32'h0000_0001;
    chk(rdv, a == 8'h26 ? {30'b0, dual_dc_fitted, high_voltage_module_fitted} : model[a]);
  endtask
  initial begin
    for (j = 21; j < 40; j++)
      model[j] = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (j = 21; j < 40; j++)
      rd(j[7:0]);
    // Phases: high voltage module, no module, dual modules
    for (p = 0; p < 3; p++) begin
      idle();
      high_voltage_module_fitted <= (p == 0);
      dual_dc_fitted <= (p == 2);
      @(posedge pclk);
      wr(8'h1f, 32'h0000_8000, 4'hf);
      rd(8'h1f);
      repeat (90) begin
        r = xs();
        i = 8'h15 + 8'(r[4:0] % 19);
        d = mx(i) == 8'hff ? {16'h0000, r[31:16]} : {29'h0, r[7:5]};
        wr(i, d, r[10] ? 4'hf : {2'b00, r[11], !r[11]});
        rd(8'h27);
        rd(i);
      end
      idle();
      chk(bomb_active_ramp, high_voltage_module_fitted ? model[35] : 32'h0000_0000);
      chk(ch2_active_ramp, dual_dc_fitted ? model[35] : 32'h0000_0000);
      chk(res_active_ramp, model[31]);
      chk(pv_source, model[24]);
      chk(tc_b_type, model[26]);
      chk(ramp_regulation, model[23]);
      chk(heat_bombard, high_voltage_module_fitted ? model[22] : 32'h0000_0000);
      chk(tc_a_type, model[25]);
      chk(diode_a_curve, model[27]);
      chk(diode_b_curve, model[28]);
      chk(work_mode, model[21]);
      chk(pv_unit, model[30]);
      chk(res_active_ramp_unit, model[32]);
      chk(res_idle_ramp, model[33]);
      chk(res_idle_ramp_unit, model[34]);
      chk(bomb_idle_ramp, high_voltage_module_fitted ? model[37] : 32'h0000_0000);
      chk(bomb_active_ramp_unit, high_voltage_module_fitted ? model[36] : 32'h0000_0000);
      chk(ch2_idle_ramp, dual_dc_fitted ? model[37] : 32'h0000_0000);
      chk(ch2_active_ramp_unit, dual_dc_fitted ? model[36] : 32'h0000_0000);
    end
    extern_control_active <= 1;
    volt_input_active <= 1;
    apb(0, 8'h15, 32'h0000_0000, 4'h0);
    chk(rdv, 32'h0000_0002);
    apb(0, 8'h1e, 32'h0000_0000, 4'h0);
    chk(rdv, 32'h0000_0003);
    regulator_output_active <= 1;
    wr(8'h15, 32'h0000_0002, 4'hf);
    apb(0, 8'h15, 32'h0000_0000, 4'h0);
    chk(rdv, 32'h0000_0003);
    wr(8'h1e, 32'h0000_0003, 4'hf);
    idle();
    extern_control_active <= 0;
    regulator_output_active <= 0;
    volt_input_active <= 0;
    rd(8'h15);
    rd(8'h1e);
    wr(8'h10, xs(), 4'hf);
    rd(8'h27);
    idle();
    results();
  end
endmodule // hcrb_bank_tb_top
`default_nettype wire
